// ---- verilog/rtle_defs.svh ----
// constants for the ram transfer and table lookup execution block
`ifndef RTLE_DEFS_SVH
`define RTLE_DEFS_SVH

// ****************************************************************
// opcode fields
// ****************************************************************
`define RTLE_OP_W          10         // instruction word width
`define RTLE_GRP_HI        9          // group field top bit
`define RTLE_GRP_LO        4          // group field bottom bit
`define RTLE_GRP_LOAD      6'h2C      // load accumulator from ram, low nibble j
`define RTLE_GRP_SWAP      6'h2D      // swap accumulator with ram
`define RTLE_GRP_SWAP_INC  6'h2E      // swap then row increment
`define RTLE_GRP_SWAP_DEC  6'h2F      // swap then row decrement
`define RTLE_GRP_STORE     6'h2B      // store accumulator to ram
`define RTLE_GRP_LDI       6'h07      // load immediate
`define RTLE_TBL_HI        9          // lookup prefix top bit
`define RTLE_TBL_LO        6          // lookup prefix bottom bit
`define RTLE_TBL_PREFIX    4'h2       // lookup prefix value, page in bits 5..0
`define RTLE_PAGE_FIELD_W  6          // width of the page operand field

// ****************************************************************
// wrap values of the row register
// ****************************************************************
`define RTLE_ROW_TOP       4'hF       // decrement wraps to this
`define RTLE_ROW_BOTTOM    4'h0       // increment wraps to this

// ****************************************************************
// reset values and sizes
// ****************************************************************
`define RTLE_NIB_RESET     4'h0       // nibble registers after reset
`define RTLE_LEVEL_RESET   3'h0       // stack level after reset
`define RTLE_LOW_W         7          // in-page address width
`define RTLE_LOOKUP_CYCLES 3          // cycles taken by a table lookup

`endif

// ---- verilog/rtle_pkg.sv ----
// types shared by the ram transfer and table lookup execution block
package rtle_pkg;

  // ****************************************************************
  // table lookup sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    RTLE_ST_IDLE = 2'b00,   // decoding one instruction per cycle
    RTLE_ST_ADDR = 2'b01,   // rom address presented
    RTLE_ST_DATA = 2'b10    // rom data captured, counter restored
  } rtle_state_type;

  // ****************************************************************
  // decoded operation
  // ****************************************************************
  typedef enum logic [2:0] {
    RTLE_OP_OTHER    = 3'b000,  // not this group
    RTLE_OP_LOAD     = 3'b001,  // load_acc_from_ram
    RTLE_OP_SWAP     = 3'b010,  // swap_acc_ram
    RTLE_OP_SWAP_DEC = 3'b011,  // swap_then_row_dec
    RTLE_OP_SWAP_INC = 3'b100,  // swap_then_row_inc
    RTLE_OP_STORE    = 3'b101,  // store_acc_to_ram
    RTLE_OP_LDI      = 3'b110,  // load_immediate
    RTLE_OP_TABLE    = 3'b111   // rom_table_lookup
  } rtle_op_type;

endpackage

// ---- verilog/rtle_stack.sv ----
// return stack memory used by the table lookup to save the counter
`timescale 1ns/1ps
`include "rtle_defs.svh"

module rtle_stack #(
  parameter int DEPTH  = 8,   // number of stack levels
  parameter int LVL_W  = 3,   // level index width
  parameter int PC_W   = 13   // saved counter width
) (
  mclk,
  wr_en,
  wr_level,
  wr_data,
  rd_level,
  rd_data
);
  input  wire logic             mclk;      // instruction clock
  input  wire logic             wr_en;     // store one counter value
  input  wire logic [LVL_W-1:0] wr_level;  // level written
  input  wire logic [PC_W-1:0]  wr_data;   // counter value to save
  input  wire logic [LVL_W-1:0] rd_level;  // level read
  output logic      [PC_W-1:0]  rd_data;   // saved counter at rd_level

  // every level must be addressable by the index
  if (DEPTH > (1 << LVL_W) || DEPTH < 2) begin : g_bad_depth
    $error("stack depth does not fit the level index");
  end

  logic [PC_W-1:0] mem_reg [DEPTH];  // one saved counter per level

  // ****************************************************************
  // storage; no reset, contents are only meaningful after a push
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_reg[wr_level] <= wr_data;
    end
  end

  // read is combinational so the pop lands in the same cycle
  always_comb begin
    rd_data = mem_reg[rd_level];
  end

endmodule

// ---- verilog/rtle_exec.sv ----
// ram transfer, load immediate and rom table lookup execution block
//
// Contract
// - load copies ram nibble into accumulator
// - every ram transfer xors X with j
// - swap exchanges accumulator and ram nibble
// - swap, decrement Y, skip on 15
// - swap, increment Y, skip on 0
// - store writes accumulator to ram
// - load immediate puts n into accumulator
// - consecutive load immediates: only first executes
// - lookup address is page, D2..0, A3..0
// - rom high nibble to B, low to A; 3 cycles
// - lookup pushes counter, pops it, one level
// - page 0..31 small, 0..63 large variant
`timescale 1ns/1ps
`include "rtle_defs.svh"

module rtle_exec #(
  parameter int PAGE_W = 6,   // 5 on the smaller rom variant, 6 on the larger
  parameter int DEPTH  = 8,   // return stack levels
  parameter int LVL_W  = 3    // stack level width
) (
  mclk,
  reset,
  instr_valid,
  instr,
  pc_in,
  table_row_high,
  ram_rdata,
  rom_data,
  acc,
  reg_b,
  reg_x,
  reg_y,
  ram_we,
  ram_wdata,
  rom_rd,
  rom_addr,
  pc_load,
  pc_value,
  busy,
  skip_active,
  stack_level
);
  localparam int PC_W = PAGE_W + `RTLE_LOW_W;

  input  wire logic                  mclk;            // instruction clock
  input  wire logic                  reset;           // synchronous, active high
  input  wire logic                  instr_valid;     // one fetched instruction
  input  wire logic [`RTLE_OP_W-1:0] instr;           // instruction word
  input  wire logic [PC_W-1:0]       pc_in;           // counter to save on lookup
  input  wire logic [2:0]            table_row_high;  // D register
  input  wire logic [3:0]            ram_rdata;       // nibble at ram_pointer
  input  wire logic [7:0]            rom_data;        // rom word, valid cycle after rom_rd
  output logic      [3:0]            acc;             // accumulator
  output logic      [3:0]            reg_b;           // register B
  output logic      [3:0]            reg_x;           // register X
  output logic      [3:0]            reg_y;           // register Y
  output logic                       ram_we;          // write pulse to ram_pointer
  output logic      [3:0]            ram_wdata;       // nibble written
  output logic                       rom_rd;          // table read pulse
  output logic      [PC_W-1:0]       rom_addr;        // table address
  output logic                       pc_load;         // counter restore pulse
  output logic      [PC_W-1:0]       pc_value;        // counter popped from stack
  output logic                       busy;            // lookup in progress, hold fetch
  output logic                       skip_active;     // skip armed; after a load immediate only another one is skipped
  output logic      [LVL_W-1:0]      stack_level;     // stack_level pointer

  // page field cannot exceed the opcode field
  if (PAGE_W < 5 || PAGE_W > `RTLE_PAGE_FIELD_W) begin : g_bad_page
    $error("PAGE_W must be 5 or 6");
  end

  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic rtle_pkg::rtle_op_type decode(input logic [`RTLE_OP_W-1:0] w);
    logic [5:0] grp;
    grp = w[`RTLE_GRP_HI:`RTLE_GRP_LO];
    if (w[`RTLE_TBL_HI:`RTLE_TBL_LO] == `RTLE_TBL_PREFIX) begin
      decode = rtle_pkg::RTLE_OP_TABLE;
    end else begin
      case (grp)
        `RTLE_GRP_LOAD:     decode = rtle_pkg::RTLE_OP_LOAD;
        `RTLE_GRP_SWAP:     decode = rtle_pkg::RTLE_OP_SWAP;
        `RTLE_GRP_SWAP_DEC: decode = rtle_pkg::RTLE_OP_SWAP_DEC;
        `RTLE_GRP_SWAP_INC: decode = rtle_pkg::RTLE_OP_SWAP_INC;
        `RTLE_GRP_STORE:    decode = rtle_pkg::RTLE_OP_STORE;
        `RTLE_GRP_LDI:      decode = rtle_pkg::RTLE_OP_LDI;
        default:            decode = rtle_pkg::RTLE_OP_OTHER;
      endcase
    end
  endfunction

  rtle_pkg::rtle_op_type    op;          // decoded current word
  logic                     take;        // word accepted this cycle
  logic                     executes;    // accepted and not skipped
  logic [3:0]               imm;         // low nibble j or n
  logic [PAGE_W-1:0]        page;        // lookup page
  logic                     skip_eff;    // skip that applies to the current word

  // ****************************************************************
  // state
  // ****************************************************************
  rtle_pkg::rtle_state_type state_reg, state_next;      // lookup sequencer
  logic [3:0]         acc_reg, acc_next;                // accumulator
  logic [3:0]         b_reg, b_next;                    // register B
  logic [3:0]         x_reg, x_next;                    // register X
  logic [3:0]         y_reg, y_next;                    // register Y
  logic               we_reg, we_next;                  // ram write pulse
  logic [3:0]         wdata_reg, wdata_next;            // ram write data
  logic               rd_reg, rd_next;                  // rom read pulse
  logic [PC_W-1:0]    raddr_reg, raddr_next;            // rom address
  logic               pcl_reg, pcl_next;                // counter restore pulse
  logic [PC_W-1:0]    pcv_reg, pcv_next;                // restored counter
  logic               skip_reg, skip_next;              // skip pending
  logic               busy_reg, busy_next;              // lookup in progress
  logic               ldi_reg, ldi_next;                // previous word was load_immediate
  logic [LVL_W-1:0]   lvl_reg, lvl_next;                // stack_level
  logic               push;                             // save counter this cycle
  logic [PC_W-1:0]    pop_data;                         // counter at current level

  assign op       = decode(instr);
  assign take     = instr_valid && (state_reg == rtle_pkg::RTLE_ST_IDLE);
  // a load immediate arms the skip flag, but only another load immediate
  // honours it; any other word executes and ends the chain
  assign skip_eff = skip_reg && !(ldi_reg && (op != rtle_pkg::RTLE_OP_LDI));
  assign executes = take && !skip_eff;
  assign imm      = instr[3:0];
  assign page     = instr[PAGE_W-1:0];
  assign push     = executes && (op == rtle_pkg::RTLE_OP_TABLE);

  // ****************************************************************
  // next-state logic for registers, flags and lookup sequence
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    acc_next   = acc_reg;
    b_next     = b_reg;
    x_next     = x_reg;
    y_next     = y_reg;
    we_next    = 1'b0;
    wdata_next = wdata_reg;
    rd_next    = 1'b0;
    raddr_next = raddr_reg;
    pcl_next   = 1'b0;
    pcv_next   = pcv_reg;
    skip_next  = skip_reg;
    ldi_next   = ldi_reg;
    lvl_next   = lvl_reg;
    case (state_reg)
      rtle_pkg::RTLE_ST_IDLE: begin
        if (take && skip_eff) begin
          // skipped word still uses its cycle; a further load immediate
          // in the chain stays suppressed, anything else ends it
          skip_next = (op == rtle_pkg::RTLE_OP_LDI) && ldi_reg;
          ldi_next  = (op == rtle_pkg::RTLE_OP_LDI) && ldi_reg;
        end else if (take) begin
          ldi_next  = 1'b0;
          skip_next = 1'b0;   // an executed word drops any armed skip
          case (op)
            rtle_pkg::RTLE_OP_LOAD: begin
              acc_next = ram_rdata;
              x_next   = x_reg ^ imm;
            end
            rtle_pkg::RTLE_OP_SWAP: begin
              acc_next   = ram_rdata;
              we_next    = 1'b1;
              wdata_next = acc_reg;
              x_next     = x_reg ^ imm;
            end
            rtle_pkg::RTLE_OP_SWAP_DEC: begin
              acc_next   = ram_rdata;
              we_next    = 1'b1;
              wdata_next = acc_reg;
              x_next     = x_reg ^ imm;
              y_next     = y_reg - 4'h1;
              skip_next  = (y_reg == `RTLE_ROW_BOTTOM);
            end
            rtle_pkg::RTLE_OP_SWAP_INC: begin
              acc_next   = ram_rdata;
              we_next    = 1'b1;
              wdata_next = acc_reg;
              x_next     = x_reg ^ imm;
              y_next     = y_reg + 4'h1;
              skip_next  = (y_reg == `RTLE_ROW_TOP);
            end
            rtle_pkg::RTLE_OP_STORE: begin
              we_next    = 1'b1;
              wdata_next = acc_reg;
              x_next     = x_reg ^ imm;
            end
            rtle_pkg::RTLE_OP_LDI: begin
              acc_next  = imm;
              ldi_next  = 1'b1;
              skip_next = 1'b1;   // arms suppression of a following one
            end
            rtle_pkg::RTLE_OP_TABLE: begin
              // level goes up and the counter is saved
              lvl_next   = lvl_reg + {{(LVL_W-1){1'b0}}, 1'b1};
              raddr_next = {page, table_row_high, acc_reg};
              rd_next    = 1'b1;
              state_next = rtle_pkg::RTLE_ST_ADDR;
            end
            default: begin
              // other groups run elsewhere; nothing here changes
            end
          endcase
        end
      end
      rtle_pkg::RTLE_ST_ADDR: begin
        state_next = rtle_pkg::RTLE_ST_DATA;
      end
      rtle_pkg::RTLE_ST_DATA: begin
        b_next     = rom_data[7:4];
        acc_next   = rom_data[3:0];
        pcv_next   = pop_data;
        pcl_next   = 1'b1;
        lvl_next   = lvl_reg - {{(LVL_W-1){1'b0}}, 1'b1};
        state_next = rtle_pkg::RTLE_ST_IDLE;
      end
      default: begin
        state_next = rtle_pkg::RTLE_ST_IDLE;
      end
    endcase
    // busy has its own flop so the fetch hold leaves the block glitch free
    busy_next = (state_next != rtle_pkg::RTLE_ST_IDLE);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= rtle_pkg::RTLE_ST_IDLE;
      acc_reg   <= `RTLE_NIB_RESET;
      b_reg     <= `RTLE_NIB_RESET;
      x_reg     <= `RTLE_NIB_RESET;
      y_reg     <= `RTLE_NIB_RESET;
      we_reg    <= 1'b0;
      wdata_reg <= `RTLE_NIB_RESET;
      rd_reg    <= 1'b0;
      raddr_reg <= '0;
      pcl_reg   <= 1'b0;
      pcv_reg   <= '0;
      skip_reg  <= 1'b0;
      ldi_reg   <= 1'b0;
      lvl_reg   <= `RTLE_LEVEL_RESET;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
      b_reg     <= b_next;
      x_reg     <= x_next;
      y_reg     <= y_next;
      we_reg    <= we_next;
      wdata_reg <= wdata_next;
      rd_reg    <= rd_next;
      raddr_reg <= raddr_next;
      pcl_reg   <= pcl_next;
      pcv_reg   <= pcv_next;
      skip_reg  <= skip_next;
      ldi_reg   <= ldi_next;
      lvl_reg   <= lvl_next;
      busy_reg  <= busy_next;
    end
  end

  // ****************************************************************
  // return stack; write goes to the level just above the current one
  // ****************************************************************
  rtle_stack #(
    .DEPTH (DEPTH),
    .LVL_W (LVL_W),
    .PC_W  (PC_W)
  ) u_stack (
    .mclk     (mclk),
    .wr_en    (push),
    .wr_level (lvl_reg + {{(LVL_W-1){1'b0}}, 1'b1}),
    .wr_data  (pc_in),
    .rd_level (lvl_reg),
    .rd_data  (pop_data)
  );

  assign acc         = acc_reg;
  assign reg_b       = b_reg;
  assign reg_x       = x_reg;
  assign reg_y       = y_reg;
  assign ram_we      = we_reg;
  assign ram_wdata   = wdata_reg;
  assign rom_rd      = rd_reg;
  assign rom_addr    = raddr_reg;
  assign pc_load     = pcl_reg;
  assign pc_value    = pcv_reg;
  assign busy        = busy_reg;
  assign skip_active = skip_reg;   // armed skip; a chain only suppresses load immediates
  assign stack_level = lvl_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_load_acc: assert property (executes && op == rtle_pkg::RTLE_OP_LOAD
    |=> acc_reg == $past(ram_rdata) && x_reg == ($past(x_reg) ^ $past(imm)))
    else $error("load did not take ram nibble");
  a_xor_x: assert property (executes && op == rtle_pkg::RTLE_OP_STORE
    |=> x_reg == ($past(x_reg) ^ $past(imm)))
    else $error("x not updated by xor");
  a_swap_pair: assert property (executes && op == rtle_pkg::RTLE_OP_SWAP
    |=> ram_we && wdata_reg == $past(acc_reg) && acc_reg == $past(ram_rdata))
    else $error("swap did not exchange");
  a_dec_skip: assert property (executes && op == rtle_pkg::RTLE_OP_SWAP_DEC
    |=> y_reg == $past(y_reg) - 4'h1 && skip_reg == (y_reg == `RTLE_ROW_TOP))
    else $error("decrement skip wrong");
  a_inc_skip: assert property (executes && op == rtle_pkg::RTLE_OP_SWAP_INC
    |=> y_reg == $past(y_reg) + 4'h1 && skip_reg == (y_reg == `RTLE_ROW_BOTTOM))
    else $error("increment skip wrong");
  a_store_write: assert property (executes && op == rtle_pkg::RTLE_OP_STORE
    |=> ram_we && wdata_reg == $past(acc_reg))
    else $error("store did not write");
  a_ldi_value: assert property (executes && op == rtle_pkg::RTLE_OP_LDI
    |=> acc_reg == $past(imm) && ldi_reg)
    else $error("load immediate wrong");
  a_ldi_chain: assert property (take && skip_reg && ldi_reg
    && op == rtle_pkg::RTLE_OP_LDI |=> $stable(acc_reg) && skip_reg)
    else $error("second load immediate executed");
  a_tbl_addr: assert property (push
    |=> rom_rd && rom_addr == {$past(page), $past(table_row_high), $past(acc_reg)})
    else $error("lookup address wrong");
  a_tbl_len: assert property (push
    |=> busy ##1 busy ##1 !busy && pc_load && acc_reg == $past(rom_data[3:0])
        && reg_b == $past(rom_data[7:4]))
    else $error("lookup sequence wrong");
  a_tbl_stack: assert property (push
    |=> stack_level == $past(lvl_reg) + 1'b1 ##2 stack_level == $past(lvl_reg, 3)
        && pc_value == $past(pc_in, 3))
    else $error("stack not restored");
  a_skip_quiet: assert property (take && skip_eff
    |=> $stable(acc_reg) && $stable(x_reg) && $stable(y_reg) && !ram_we && !rom_rd)
    else $error("skipped word changed state");

  c_swap_dec_wrap: cover property (executes && op == rtle_pkg::RTLE_OP_SWAP_DEC
    && y_reg == 4'h0);
  c_swap_inc_wrap: cover property (executes && op == rtle_pkg::RTLE_OP_SWAP_INC
    && y_reg == 4'hF);
  c_ldi_pair: cover property (executes && op == rtle_pkg::RTLE_OP_LDI
    ##1 take && op == rtle_pkg::RTLE_OP_LDI);
  c_lookup: cover property (push ##2 pc_load);

endmodule

// ---- verification/rtle_exec_tb.sv ----
// self-checking testbench for the ram transfer and table lookup execution block
`timescale 1ns/1ps
`include "rtle_defs.svh"

module tb;
  localparam int PG = 6;       // larger rom variant, page 0..63
  localparam int PW = PG + 7;  // counter width

  // one expected result per accepted instruction
  typedef struct {
    logic          tbl;
    logic [PW-1:0] addr, pcv;
    logic [3:0]    a, b, x, y, wd;
    logic          we;
    logic          skp;
  } rtle_exp_type;

  logic          mclk = 1'b0;      // instruction clock
  logic          reset = 1'b1;     // synchronous reset
  logic          instr_valid = 1'b0;
  logic [9:0]    instr = 10'h000;
  logic [PW-1:0] pc_in = '0;
  logic [2:0]    table_row_high = 3'h0;
  logic [3:0]    ram_rdata = 4'h0;
  logic [7:0]    rom_data;
  logic [3:0]    acc, reg_b, reg_x, reg_y, ram_wdata;
  logic          ram_we, rom_rd, pc_load, busy, skip_active;
  logic [PW-1:0] rom_addr, pc_value;
  logic [2:0]    stack_level;
  rtle_exp_type  q[$];             // notes from driver to monitor
  logic [3:0]    m_a = 4'h0, m_b = 4'h0, m_x = 4'h0, m_y = 4'h0;
  logic          skip_n = 1'b0, chain = 1'b0;
  int            n_fail = 0, check_count = 0, cyc = 0;

  // rom contents: a simple address scramble so every bit of the address matters
  function automatic logic [7:0] romf(input logic [PW-1:0] ad);
    return ad[7:0] ^ {ad[12:8], 3'h5};
  endfunction
  assign rom_data = romf(rom_addr);

  always #25 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  rtle_exec #(.PAGE_W(PG), .DEPTH(8), .LVL_W(3)) uut (
    .mclk(mclk), .reset(reset), .instr_valid(instr_valid), .instr(instr), .pc_in(pc_in),
    .table_row_high(table_row_high), .ram_rdata(ram_rdata), .rom_data(rom_data),
    .acc(acc), .reg_b(reg_b), .reg_x(reg_x), .reg_y(reg_y), .ram_we(ram_we),
    .ram_wdata(ram_wdata), .rom_rd(rom_rd), .rom_addr(rom_addr), .pc_load(pc_load),
    .pc_value(pc_value), .busy(busy), .skip_active(skip_active), .stack_level(stack_level));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // drive one word, model its effect, note the result; called just after an edge
  task automatic issue(input logic [9:0] w, input logic [3:0] rd);
    rtle_exp_type e;
    logic         sk;
    sk = skip_n;
    skip_n = 1'b0;
    instr = w;
    instr_valid = 1'b1;
    ram_rdata = rd;
    table_row_high = 3'($urandom);
    pc_in = PW'($urandom);
    e = '{default: '0};
    e.tbl = (w[9:6] == 4'h2);
    if (sk) begin
      // wrap skip: word is consumed, nothing moves
    end else if (e.tbl) begin
      e.addr = {w[5:0], table_row_high, m_a};
      e.pcv = pc_in;
      {m_b, m_a} = romf(e.addr);
      chain = 1'b0;
    end else if (w[9:4] == `RTLE_GRP_LDI) begin
      if (!chain) m_a = w[3:0];
      chain = 1'b1;
    end else begin
      chain = 1'b0;
      if (w[9:4] inside {6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h2F}) m_x = m_x ^ w[3:0];
      if (w[9:4] inside {6'h2B, 6'h2D, 6'h2E, 6'h2F}) begin
        e.we = 1'b1;
        e.wd = m_a;
      end
      if (w[9:6] == 4'hB) m_a = rd;
      if (w[9:4] == 6'h2E) begin
        m_y = m_y + 4'h1;
        skip_n = (m_y == 4'h0);
      end
      if (w[9:4] == 6'h2F) begin
        m_y = m_y - 4'h1;
        skip_n = (m_y == 4'hF);
      end
    end
    {e.a, e.b, e.x, e.y} = {m_a, m_b, m_x, m_y};
    e.skp = skip_n || chain;
    q.push_back(e);
    @(posedge mclk);
    #1;
    if (e.tbl) begin
      // words offered while busy must be ignored
      instr = 10'h2E5;
      repeat (2) begin
        @(posedge mclk);
        #1;
      end
    end
  endtask

  // ****************************************************************
  // monitor: pops the oldest note whenever a result shows
  // ****************************************************************
  initial begin
    rtle_exp_type e;
    logic         take, tbl;
    int           t0;
    forever begin
      @(negedge mclk);
      take = !reset && instr_valid && busy === 1'b0;
      tbl = (instr[9:6] == 4'h2);
      @(posedge mclk);
      #3;
      if (take && tbl) begin
        e = q[0];
        t0 = cyc;
        chk(rom_rd, 1'b1, "rom_rd");
        chk(rom_addr, e.addr, "rom_addr");
        chk(busy, 1'b1, "busy");
        chk(stack_level, 3'h1, "level_push");
      end else if (take) begin
        e = q.pop_front();
        chk(acc, e.a, "acc");
        chk(reg_x, e.x, "reg_x");
        chk(reg_y, e.y, "reg_y");
        chk(ram_we, e.we, "ram_we");
        if (e.we) chk(ram_wdata, e.wd, "ram_wdata");
        chk(skip_active, e.skp, "skip_active");
      end
      if (pc_load === 1'b1) begin
        e = q.pop_front();
        chk(16'(cyc - t0), 16'h2, "lookup_len");
        chk({reg_b, acc, reg_x, reg_y}, {e.b, e.a, e.x, e.y}, "lookup_regs");
        chk(pc_value, e.pcv, "pc_value");
        chk(stack_level, 3'h0, "level_pop");
        chk(busy, 1'b0, "busy_end");
      end
    end
  end

  // watchdog sized well above the planned run
  initial begin
    #(5000 * 50);
    n_fail++;
    close_out();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [5:0] ops [7];
    logic [5:0] op;
    ops = '{6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h2B, 6'h07, 6'h00};
    void'($urandom(32'hd7c0af00));
    repeat (5) @(posedge mclk);
    #1;
    reset = 1'b0;
    @(posedge mclk);
    #1;
    issue(10'h2C5, 4'h9);
    issue(10'h2B3, 4'h1);
    issue(10'h2DA, 4'h6);
    issue(10'h073, 4'h0);
    issue(10'h079, 4'h0);
    issue(10'h07C, 4'h0);
    issue(10'h000, 4'h0);
    issue(10'h074, 4'h0);
    // row wrap both ways, each followed by a skipped word
    issue(10'h2F0, 4'h2);
    issue(10'h2C7, 4'hE);
    issue(10'h2E0, 4'h3);
    issue(10'h2B1, 4'h5);
    for (int i = 0; i < 200; i++) begin
      op = ops[$urandom % 7];
      if (skip_n && op == 6'h07) op = 6'h2C;
      issue({op, 4'($urandom)}, 4'($urandom));
    end
    issue(10'h000, 4'h0);
    // lookups back to back, page boundaries first
    for (int i = 0; i < 10; i++) begin
      issue(10'h080 | 10'(i < 5 ? (i == 2 ? 31 : i == 3 ? 32 : i * 63 / 4) : $urandom % 64), 4'h0);
    end
    issue(10'h2C1, 4'h8);
    instr_valid = 1'b0;
    repeat (5) @(posedge mclk);
    chk(16'(q.size()), 16'h0, "notes_left");
    close_out();
  end
endmodule
